// ==== ritdi_timer.sv ====
// Shared constants and the interval timer of the RAM/I-O/timer block
`timescale 1ns/1ps
package ritdi_pkg;
	// ==========================================================
	// Address field positions
	localparam int ADDR_W = 7;
	localparam int A_SEL0 = 0;
	localparam int A_SEL1 = 1;
	localparam int A_TIMER = 2;
	localparam int A_IRQ_EN = 3;
	localparam int A_TWRITE = 4;
	// ==========================================================
	// I/O register select codes on address bits 1..0
	localparam logic [1:0] IO_PA_OUT = 2'h0;
	localparam logic [1:0] IO_PA_DIR = 2'h1;
	localparam logic [1:0] IO_PB_OUT = 2'h2;
	localparam logic [1:0] IO_PB_DIR = 2'h3;
	// ==========================================================
	// Interval codes and the last prescaler value of each
	localparam logic [1:0] DIV_1 = 2'h0;
	localparam logic [1:0] DIV_8 = 2'h1;
	localparam logic [1:0] DIV_64 = 2'h2;
	localparam logic [1:0] DIV_1024 = 2'h3;
	localparam int PRE_W = 10;
	localparam logic [PRE_W-1:0] PRE_LAST_1 = 10'h000;
	localparam logic [PRE_W-1:0] PRE_LAST_8 = 10'h007;
	localparam logic [PRE_W-1:0] PRE_LAST_64 = 10'h03f;
	localparam logic [PRE_W-1:0] PRE_LAST_1024 = 10'h3ff;
	// ==========================================================
	// Flag register layout and reset values
	localparam int FLAG_TIMER = 7;
	localparam int FLAG_EDGE = 6;
	localparam logic [7:0] PORT_RST = 8'h00;
	localparam logic [7:0] COUNT_RST = 8'h00;
	localparam logic [7:0] RAM_RST = 8'h00;
	localparam int RAM_DEPTH = 128;
	localparam logic [7:0] PIN_IDLE = 8'hff;

	function automatic logic [PRE_W-1:0] pre_last(input logic [1:0] sel);
		logic [PRE_W-1:0] v;
		v = PRE_LAST_1;
		unique case (sel)
			DIV_1: v = PRE_LAST_1;
			DIV_8: v = PRE_LAST_8;
			DIV_64: v = PRE_LAST_64;
			DIV_1024: v = PRE_LAST_1024;
		endcase
		return v;
	endfunction
endpackage

module ritdi_timer (
	input wire logic clk, // System clock
	input wire logic rst, // Synchronous reset, high
	input wire logic load, // Write strobe, one cycle
	input wire logic [7:0] load_val, // Interval count to start from
	input wire logic [1:0] div_sel, // Interval select
	output logic [7:0] count, // Current counter value
	output logic timeout // One-cycle pulse at timeout
);
	typedef struct packed {
		logic [7:0] count;
		logic [ritdi_pkg::PRE_W-1:0] pre;
		logic [ritdi_pkg::PRE_W-1:0] last;
		logic fast;
		logic tout;
	} ritdi_tmr_t;

	ritdi_tmr_t st_r;
	ritdi_tmr_t st_nxt;

	// ==========================================================
	// Counter
	always_comb begin
		st_nxt = st_r;
		st_nxt.tout = 1'b0;
		if (load) begin
			st_nxt.count = load_val;
			st_nxt.last = ritdi_pkg::pre_last(div_sel);
			st_nxt.pre = ritdi_pkg::pre_last(div_sel);
			st_nxt.fast = 1'b0;
		end else if (st_r.fast) begin
			// Past timeout the count runs at clock rate to show elapsed time
			st_nxt.count = st_r.count - 8'h01;
		end else if (st_r.pre == '0) begin
			st_nxt.pre = st_r.last;
			st_nxt.count = st_r.count - 8'h01;
			if (st_r.count == 8'h00) begin
				st_nxt.fast = 1'b1;
				st_nxt.tout = 1'b1;
			end
		end else begin
			st_nxt.pre = st_r.pre - 10'h001;
		end
		if (rst) begin
			// Reset parks the timer as already expired, with no pending pulse
			st_nxt.count = ritdi_pkg::COUNT_RST;
			st_nxt.pre = '0;
			st_nxt.last = ritdi_pkg::PRE_LAST_1;
			st_nxt.fast = 1'b1;
			st_nxt.tout = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		st_r <= st_nxt;
	end

	assign count = st_r.count;
	assign timeout = st_r.tout;

	// ==========================================================
	// Checks
	property p_tmr_load;
		@(posedge clk) disable iff (rst)
		load |=> count == $past(load_val) && !timeout;
	endproperty
	a_tmr_load: assert property (p_tmr_load) else $error("timer load lost");

	property p_tmr_fast;
		@(posedge clk) disable iff (rst)
		(timeout && !load) |=> count == $past(count) - 8'h01;
	endproperty
	a_tmr_fast: assert property (p_tmr_fast) else $error("no clock-rate count");
endmodule

// ==== ritdi_top.sv ====
// RAM, port, timer decode and interrupt logic of the peripheral
// Behaviour
// - Flag register holds timer and edge flags; a read puts both on the bus.
// - Reading the flag register clears the edge flag.
// - Any read or write of the timer clears the timer flag.
// - RAM selected when high select high, low select low, memory select low.
// - With memory select high, address bit 2 picks timer (1) or I/O (0).
// - Bits 1..0 pick port A out, A direction, B out, B direction; all RW.
// - Timer write needs bits 4 and 2 high; bits 1..0 pick 1/8/64/1024.
// - Every timer access latches address bit 3 as timer interrupt enable.
// - Timer-space read: bit 0 low gives count, high gives flags.
// - Write with bit 4 low loads edge enable (bit 1) and polarity (bit 0).
// - Selected edge on the sense pin sets flag bit 6; request if enabled.
// - Edge flag sets whatever the sense pin direction.
// - Reset disables edge interrupt, picks falling edge; edge may still set flag.
// - Timeout sets flag bit 7 whether or not enabled.
// - Request idles released and pulls low; open drain, wire-OR capable.
// - Direction bit 0 makes pin input, 1 drives it from output register.
// - After timeout the count drops each clock, read as two's complement.
`timescale 1ns/1ps
module ritdi_top (
	input wire logic CORE_CLK, // 50 MHz system clock
	input wire logic SYS_RST, // Synchronous reset, high
	input wire logic BUS_STROBE, // One cycle per bus access
	input wire logic CHIP_SEL_HIGH, // Select, active high
	input wire logic CHIP_SEL_LOW_N, // Select, active low
	input wire logic MEMORY_SELECT_N, // Low picks RAM, high picks registers
	input wire logic READ_NOT_WRITE, // 1 read, 0 write
	input wire logic [6:0] ADDR, // Address
	input wire logic [7:0] DATA_IN, // Write data
	output logic [7:0] DATA_OUT, // Read data
	output logic DATA_OE, // Read data driven
	input wire logic [7:0] PORT_A_IN, // Port A pin levels
	output logic [7:0] PORT_A_OUT, // Port A drive value
	output logic [7:0] PORT_A_OE, // Port A drive enables
	output logic [7:0] PORT_B_OUT, // Port B drive value
	output logic [7:0] PORT_B_OE, // Port B drive enables
	output logic IRQ_N_OUT, // Request pin value, always low
	output logic IRQ_N_OE // Request pin pulled low
);
	typedef struct packed {
		logic [ritdi_pkg::RAM_DEPTH-1:0][7:0] ram;
		logic [7:0] pa_out;
		logic [7:0] pa_dir;
		logic [7:0] pb_out;
		logic [7:0] pb_dir;
		logic [7:0] sync1;
		logic [7:0] sync2;
		logic [7:0] sync3;
		logic [7:0] pins;
		logic tflag;
		logic eflag;
		logic ten;
		logic een;
		logic rise;
		logic [7:0] rdata;
		logic roe;
	} ritdi_state_t;

	ritdi_state_t st_r;
	ritdi_state_t st_nxt;
	logic [7:0] tmr_count;
	logic tmr_tout;

	// ==========================================================
	// Address decode
	logic sel;
	logic ram_acc;
	logic reg_acc;
	logic io_acc;
	logic tsp_acc;
	logic tmr_wr;
	logic edge_wr;
	logic tmr_rd;
	logic flag_rd;
	logic tmr_acc;
	logic edge_hit;
	logic [7:0] flag_byte;

	always_comb begin
		sel = BUS_STROBE && CHIP_SEL_HIGH && !CHIP_SEL_LOW_N;
		ram_acc = sel && !MEMORY_SELECT_N;
		reg_acc = sel && MEMORY_SELECT_N;
		io_acc = reg_acc && !ADDR[ritdi_pkg::A_TIMER];
		tsp_acc = reg_acc && ADDR[ritdi_pkg::A_TIMER];
		tmr_wr = tsp_acc && !READ_NOT_WRITE && ADDR[ritdi_pkg::A_TWRITE];
		edge_wr = tsp_acc && !READ_NOT_WRITE && !ADDR[ritdi_pkg::A_TWRITE];
		tmr_rd = tsp_acc && READ_NOT_WRITE && !ADDR[ritdi_pkg::A_SEL0];
		flag_rd = tsp_acc && READ_NOT_WRITE && ADDR[ritdi_pkg::A_SEL0];
		tmr_acc = tmr_wr || tmr_rd;
		flag_byte = 8'h00;
		flag_byte[ritdi_pkg::FLAG_TIMER] = st_r.tflag;
		flag_byte[ritdi_pkg::FLAG_EDGE] = st_r.eflag;
	end

	// ==========================================================
	// Interval timer
	ritdi_timer u_timer (
		.clk(CORE_CLK),
		.rst(SYS_RST),
		.load(tmr_wr),
		.load_val(DATA_IN),
		.div_sel(ADDR[ritdi_pkg::A_SEL1:ritdi_pkg::A_SEL0]),
		.count(tmr_count),
		.timeout(tmr_tout)
	);

	// ==========================================================
	// State update
	always_comb begin
		st_nxt = st_r;
		st_nxt.roe = 1'b0;
		// Pin synchroniser; a level counts only once stages two and three agree
		st_nxt.sync1 = PORT_A_IN;
		st_nxt.sync2 = st_r.sync1;
		st_nxt.sync3 = st_r.sync2;
		for (int i = 0; i < 8; i++) begin
			if (st_r.sync2[i] == st_r.sync3[i]) begin
				st_nxt.pins[i] = st_r.sync3[i];
			end
		end
		// Sensing looks at the pin itself, so direction has no say
		edge_hit = (st_nxt.pins[7] != st_r.pins[7]) && (st_nxt.pins[7] == st_r.rise);

		if (ram_acc && !READ_NOT_WRITE) begin
			st_nxt.ram[ADDR] = DATA_IN;
		end
		if (io_acc && !READ_NOT_WRITE) begin
			unique case (ADDR[ritdi_pkg::A_SEL1:ritdi_pkg::A_SEL0])
				ritdi_pkg::IO_PA_OUT: st_nxt.pa_out = DATA_IN;
				ritdi_pkg::IO_PA_DIR: st_nxt.pa_dir = DATA_IN;
				ritdi_pkg::IO_PB_OUT: st_nxt.pb_out = DATA_IN;
				ritdi_pkg::IO_PB_DIR: st_nxt.pb_dir = DATA_IN;
			endcase
		end
		if (tmr_acc) begin
			st_nxt.ten = ADDR[ritdi_pkg::A_IRQ_EN];
			st_nxt.tflag = 1'b0;
		end
		if (edge_wr) begin
			st_nxt.een = ADDR[ritdi_pkg::A_SEL1];
			st_nxt.rise = ADDR[ritdi_pkg::A_SEL0];
		end
		if (flag_rd) begin
			st_nxt.eflag = 1'b0;
		end
		// A new event beats a clear in the same cycle
		if (tmr_tout) begin
			st_nxt.tflag = 1'b1;
		end
		if (edge_hit) begin
			st_nxt.eflag = 1'b1;
		end

		// Read data is captured before the flag clears take effect
		if (sel && READ_NOT_WRITE) begin
			st_nxt.roe = 1'b1;
			if (ram_acc) begin
				st_nxt.rdata = st_r.ram[ADDR];
			end else if (io_acc) begin
				unique case (ADDR[ritdi_pkg::A_SEL1:ritdi_pkg::A_SEL0])
					// Port A reads the pins, port B its own register
					ritdi_pkg::IO_PA_OUT: st_nxt.rdata = st_r.pins;
					ritdi_pkg::IO_PA_DIR: st_nxt.rdata = st_r.pa_dir;
					ritdi_pkg::IO_PB_OUT: st_nxt.rdata = st_r.pb_out;
					ritdi_pkg::IO_PB_DIR: st_nxt.rdata = st_r.pb_dir;
				endcase
			end else if (flag_rd) begin
				st_nxt.rdata = flag_byte;
			end else begin
				st_nxt.rdata = tmr_count;
			end
		end

		if (SYS_RST) begin
			st_nxt.ram = '0;
			st_nxt.pa_out = ritdi_pkg::PORT_RST;
			st_nxt.pa_dir = ritdi_pkg::PORT_RST;
			st_nxt.pb_out = ritdi_pkg::PORT_RST;
			st_nxt.pb_dir = ritdi_pkg::PORT_RST;
			// Idle high as on the pull-ups, so a pin high at release gives no false edge
			st_nxt.sync2 = ritdi_pkg::PIN_IDLE;
			st_nxt.sync3 = ritdi_pkg::PIN_IDLE;
			st_nxt.pins = ritdi_pkg::PIN_IDLE;
			st_nxt.tflag = 1'b0;
			st_nxt.ten = 1'b0;
			st_nxt.een = 1'b0;
			st_nxt.rise = 1'b0;
			// A pin held low through reset lands as a falling edge just after release
			st_nxt.eflag = 1'b0;
			st_nxt.rdata = ritdi_pkg::RAM_RST;
			st_nxt.roe = 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		st_r <= st_nxt;
	end

	// ==========================================================
	// Outputs
	assign DATA_OUT = st_r.rdata;
	assign DATA_OE = st_r.roe;
	assign PORT_A_OUT = st_r.pa_out;
	assign PORT_A_OE = st_r.pa_dir;
	assign PORT_B_OUT = st_r.pb_out;
	assign PORT_B_OE = st_r.pb_dir;
	assign IRQ_N_OUT = 1'b0;
	assign IRQ_N_OE = (st_r.tflag && st_r.ten) || (st_r.eflag && st_r.een);

	// ==========================================================
	// Checks
	property p_flag_read;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		flag_rd |=> DATA_OE && DATA_OUT == {$past(st_r.tflag), $past(st_r.eflag), 6'h00};
	endproperty
	a_flag_read: assert property (p_flag_read) else $error("flag read wrong");

	property p_edge_clear;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(flag_rd && !edge_hit) |=> !st_r.eflag;
	endproperty
	a_edge_clear: assert property (p_edge_clear) else $error("edge flag kept");

	property p_timer_clear;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(tmr_acc && !tmr_tout) |=> !st_r.tflag;
	endproperty
	a_timer_clear: assert property (p_timer_clear) else $error("timer flag kept");

	property p_ram_write;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(ram_acc && !READ_NOT_WRITE) |=> st_r.ram[$past(ADDR)] == $past(DATA_IN);
	endproperty
	a_ram_write: assert property (p_ram_write) else $error("RAM write lost");

	property p_dir_write;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(io_acc && !READ_NOT_WRITE && ADDR[1:0] == 2'h1) |=> PORT_A_OE == $past(DATA_IN);
	endproperty
	a_dir_write: assert property (p_dir_write) else $error("direction write lost");

	property p_ten_latch;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		tmr_acc |=> st_r.ten == $past(ADDR[3]);
	endproperty
	a_ten_latch: assert property (p_ten_latch) else $error("timer enable not latched");

	property p_edge_ctl;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		edge_wr |=> st_r.een == $past(ADDR[1]) && st_r.rise == $past(ADDR[0]);
	endproperty
	a_edge_ctl: assert property (p_edge_ctl) else $error("edge control lost");

	property p_edge_set;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		edge_hit |=> st_r.eflag;
	endproperty
	a_edge_set: assert property (p_edge_set) else $error("edge missed");

	property p_tout_set;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		tmr_tout |=> st_r.tflag;
	endproperty
	a_tout_set: assert property (p_tout_set) else $error("timeout missed");

	property p_irq;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(st_r.tflag && st_r.ten) || (st_r.eflag && st_r.een) |-> IRQ_N_OE && !IRQ_N_OUT;
	endproperty
	a_irq: assert property (p_irq) else $error("request not pulled");

	property p_unselected;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		!sel |=> !DATA_OE && $stable(st_r.pa_dir) && $stable(st_r.ten);
	endproperty
	a_unselected: assert property (p_unselected) else $error("unselected change");

	property p_pa_read;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(io_acc && READ_NOT_WRITE && ADDR[1:0] == ritdi_pkg::IO_PA_OUT)
			|=> DATA_OUT == $past(st_r.pins);
	endproperty
	a_pa_read: assert property (p_pa_read) else $error("port A read not from pins");

	property p_pb_read;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(io_acc && READ_NOT_WRITE && ADDR[1:0] == ritdi_pkg::IO_PB_OUT)
			|=> DATA_OUT == $past(PORT_B_OUT);
	endproperty
	a_pb_read: assert property (p_pb_read) else $error("port B read wrong");

	property p_ram_read;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(ram_acc && READ_NOT_WRITE) |=> DATA_OE && DATA_OUT == $past(st_r.ram[ADDR]);
	endproperty
	a_ram_read: assert property (p_ram_read) else $error("RAM read wrong");

	property p_tmr_read;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		tmr_rd |=> DATA_OE && DATA_OUT == $past(tmr_count);
	endproperty
	a_tmr_read: assert property (p_tmr_read) else $error("timer read wrong");

	property p_rst_ctl;
		@(posedge CORE_CLK)
		SYS_RST |=> !st_r.een && !st_r.rise && !st_r.ten && !DATA_OE;
	endproperty
	a_rst_ctl: assert property (p_rst_ctl) else $error("reset control state wrong");

	property p_irq_rise;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		$rose(IRQ_N_OE) |-> $past(tmr_tout) || $past(edge_hit) || $past(tmr_acc) || $past(edge_wr);
	endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("request with no cause");

	property p_rd_oe;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		sel |=> DATA_OE == $past(READ_NOT_WRITE);
	endproperty
	a_rd_oe: assert property (p_rd_oe) else $error("bus drive wrong for access");

	property p_unsel_mem;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		!sel |=> $stable(st_r.ram) && $stable(st_r.pb_out) && $stable(st_r.een);
	endproperty
	a_unsel_mem: assert property (p_unsel_mem) else $error("unselected store change");

	property p_tflag_hold;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(st_r.tflag && !tmr_acc) |=> st_r.tflag;
	endproperty
	a_tflag_hold: assert property (p_tflag_hold) else $error("timer flag lost");

	property p_eflag_hold;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(st_r.eflag && !flag_rd) |=> st_r.eflag;
	endproperty
	a_eflag_hold: assert property (p_eflag_hold) else $error("edge flag lost");
endmodule

// ==== ritdi_pin_model.sv ====
// Port A pin model: device drive, pull-ups and an external source per pin
`timescale 1ns/1ps
module ritdi_pin_model (
	input wire logic [7:0] drv_val, // Device drive value
	input wire logic [7:0] drv_oe, // Device drive enables
	input wire logic [7:0] ext_val, // External source value
	input wire logic [7:0] ext_en, // External source enables
	output logic [7:0] pin // Resolved pin levels
);
	// ========
	// Pin resolution
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (drv_oe[i]) begin
				pin[i] = drv_val[i];
			end else if (ext_en[i]) begin
				pin[i] = ext_val[i];
			end else begin
				// Pull-up, so a released input never floats to a stale value
				pin[i] = 1'b1;
			end
		end
	end
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the RAM, port, timer decode and interrupt block
`timescale 1ns/1ps
module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic strobe = 1'b0;
	logic cs_hi = 1'b1;
	logic cs_lo_n = 1'b0;
	logic msel_n = 1'b1;
	logic rnw = 1'b1;
	logic [6:0] addr = 7'h00;
	logic [7:0] din = 8'h00;
	logic [7:0] ext_val = 8'hff;
	logic [7:0] ext_en = 8'h00;
	logic [7:0] dout, pa_out, pa_oe, pb_out, pb_oe, pins, q, v1;
	logic irq_out, irq_oe, dout_oe, last_oe, irq_n;
	int n_mismatch = 0;
	int tests_run = 0;
	int n;
	int dv[4] = '{1, 8, 64, 1024};

	always #10 clk = ~clk;
	// Open-drain request line with its board pull-up
	assign irq_n = irq_oe ? irq_out : 1'b1;

	ritdi_top u_ritdi_top (.CORE_CLK(clk), .SYS_RST(rst), .BUS_STROBE(strobe),
		.CHIP_SEL_HIGH(cs_hi), .CHIP_SEL_LOW_N(cs_lo_n), .MEMORY_SELECT_N(msel_n),
		.READ_NOT_WRITE(rnw), .ADDR(addr), .DATA_IN(din), .DATA_OUT(dout),
		.DATA_OE(dout_oe), .PORT_A_IN(pins), .PORT_A_OUT(pa_out), .PORT_A_OE(pa_oe),
		.PORT_B_OUT(pb_out), .PORT_B_OE(pb_oe), .IRQ_N_OUT(irq_out), .IRQ_N_OE(irq_oe));
	ritdi_pin_model u_ritdi_pin_model (.drv_val(pa_out), .drv_oe(pa_oe),
		.ext_val(ext_val), .ext_en(ext_en), .pin(pins));

	// ========
	// Bus and check tasks
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic acc(input logic r, input logic m, input logic [6:0] a, input logic [7:0] d);
		@(posedge clk);
		strobe <= 1'b1;
		rnw <= r;
		msel_n <= m;
		addr <= a;
		din <= d;
		@(posedge clk);
		strobe <= 1'b0;
		#1;
		q = dout;
		last_oe = dout_oe;
	endtask
	task automatic wr(input logic m, input logic [6:0] a, input logic [7:0] d);
		acc(1'b0, m, a, d);
	endtask
	task automatic rd(input logic m, input logic [6:0] a, input logic [7:0] exp, input string what);
		acc(1'b1, m, a, 8'h00);
		chk(what, q, exp);
		chk("read_oe", {7'h00, last_oe}, 8'h01);
	endtask
	task automatic wait_irq(input int lim);
		n = 0;
		while (irq_n !== 1'b0 && n < lim) begin
			@(negedge clk);
			n++;
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ========
	// Watchdog, well beyond the longest timer interval
	initial begin
		#200000;
		n_mismatch++;
		$display("[FAIL] watchdog expected done seen hang");
		wrap_up();
	end

	// ========
	// Main sequence
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk("irq_idle", {7'h00, irq_n}, 8'h01);
		rd(1'b1, 7'h05, 8'h00, "flags_after_rst");
		@(posedge clk);
		ext_en <= 8'h80;
		ext_val <= 8'h00;
		repeat (10) @(posedge clk);
		chk("edge_masked", {7'h00, irq_n}, 8'h01);
		rd(1'b1, 7'h05, 8'h40, "edge_fall_rst");
		rd(1'b1, 7'h05, 8'h00, "edge_clr");
		wr(1'b1, 7'h01, 8'hff);
		wr(1'b1, 7'h00, 8'h5a);
		wr(1'b1, 7'h03, 8'h3c);
		wr(1'b1, 7'h02, 8'ha5);
		wr(1'b0, 7'h03, 8'h99);
		wr(1'b0, 7'h7f, 8'h42);
		rd(1'b1, 7'h00, 8'h5a, "pa_pins");
		rd(1'b1, 7'h01, 8'hff, "pa_dir");
		rd(1'b1, 7'h02, 8'ha5, "pb_out");
		rd(1'b1, 7'h03, 8'h3c, "pb_dir");
		rd(1'b0, 7'h03, 8'h99, "ram_lo");
		chk("pb_drive", pb_out, 8'ha5);
		chk("pa_drive", pa_out, 8'h5a);
		chk("pb_enable", pb_oe, 8'h3c);
		chk("pa_enable", pa_oe, 8'hff);
		// Each select dropped in turn must leave state alone
		@(posedge clk);
		cs_hi <= 1'b0;
		wr(1'b0, 7'h7f, 8'h99);
		acc(1'b1, 1'b0, 7'h7f, 8'h00);
		chk("unsel_oe", {7'h00, last_oe}, 8'h00);
		@(posedge clk);
		cs_hi <= 1'b1;
		cs_lo_n <= 1'b1;
		wr(1'b1, 7'h02, 8'h00);
		chk("unsel_pb", pb_out, 8'ha5);
		@(posedge clk);
		cs_lo_n <= 1'b0;
		rd(1'b0, 7'h7f, 8'h42, "ram_kept");
		// Data 00 on the control write shows the bus is ignored
		wr(1'b1, 7'h07, 8'h00);
		wr(1'b1, 7'h00, 8'hda);
		wait_irq(12);
		chk("edge_rise_irq", {7'h00, irq_n}, 8'h00);
		rd(1'b1, 7'h05, 8'h40, "edge_rise_flag");
		chk("edge_irq_rel", {7'h00, irq_n}, 8'h01);
		wr(1'b1, 7'h01, 8'h00);
		repeat (10) @(posedge clk);
		rd(1'b1, 7'h05, 8'h00, "fall_ignored");
		wr(1'b1, 7'h06, 8'hff);
		@(posedge clk);
		ext_val <= 8'h80;
		repeat (10) @(posedge clk);
		chk("rise_ignored", {7'h00, irq_n}, 8'h01);
		@(posedge clk);
		ext_val <= 8'h00;
		wait_irq(12);
		chk("edge_fall_irq", {7'h00, irq_n}, 8'h00);
		rd(1'b1, 7'h05, 8'h40, "edge_fall_flag");
		for (int i = 0; i < 4; i++) begin
			wr(1'b1, 7'h1c | 7'(i), 8'h02);
			// Count 2 runs three intervals, then the flag lands one clock later
			wait_irq(3200);
			chk("tmo_time", 8'(n >= 3 * dv[i] + 1 && n <= 3 * dv[i] + 3), 8'h01);
			rd(1'b1, 7'h05, 8'h80, "tmo_flag");
			acc(1'b1, 1'b1, 7'h04, 8'h00);
			chk("tmo_irq_rel", {7'h00, irq_n}, 8'h01);
			rd(1'b1, 7'h05, 8'h00, "tmo_clr");
		end
		wr(1'b1, 7'h14, 8'h02);
		repeat (10) @(posedge clk);
		chk("tmo_masked", {7'h00, irq_n}, 8'h01);
		rd(1'b1, 7'h05, 8'h80, "tmo_flag_masked");
		acc(1'b1, 1'b1, 7'h04, 8'h00);
		v1 = q;
		repeat (4) @(posedge clk);
		acc(1'b1, 1'b1, 7'h04, 8'h00);
		chk("post_tmo_step", v1 - q, 8'h06);
		rd(1'b1, 7'h05, 8'h00, "tmo_clr_read");
		wrap_up();
	end
endmodule
